// *** rtl/gpiid_detect.sv ***
// Per-pin interrupt detection for one GPIO port
// Assumes pin inputs synchronous to core_clk; config bits held by software
//
// Contract
// R1 - Every pin is an interrupt source with its own request line.
// R2 - Level mode 8 runs the pin as open-drain output.
// R3 - Level mode requests while sampled pin equals the output-level bit.
// R4 - Pin sampled by clock; level must hold two clocks before request.
// R5 - Level request stays while level matches, drops when it changes.
// R6 - Edge modes run pin open-drain and request on the selected edge.
// R7 - Dual-edge mode 6 requests on every rising and falling edge.
// R8 - Mode 6 decodes from level 1, high 1, low 0, direction 0.
// R9 - Mode 9 output-level bit picks edge: 0 falling, 1 rising.
// R10 - Mode 9 decodes from level 0 or 1, high 1, low 1, direction 1.
// R11 - Edges found by comparing successive samples; one request per edge.
`include "gpiid_cfg.svh"
`default_nettype none

module gpiid_detect
  import gpiid_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`GPIID_PINS-1:0] pin_in,
  input wire logic [`GPIID_PINS-1:0] port_output_level,
  input wire logic [`GPIID_PINS-1:0] port_direction,
  input wire logic [`GPIID_PINS-1:0] port_function_sel_low,
  input wire logic [`GPIID_PINS-1:0] port_function_sel_high,
  output logic [`GPIID_PINS-1:0] pin_out,
  output logic [`GPIID_PINS-1:0] pin_oe_n,
  output logic [`GPIID_PINS-1:0] irq_req
);

  logic [`GPIID_PINS-1:0] samp0;
  logic [`GPIID_PINS-1:0] samp1;
  logic [`GPIID_PINS-1:0] next_samp0;
  logic [`GPIID_PINS-1:0] next_samp1;
  logic [`GPIID_PINS-1:0] next_irq_req;
  gpiid_mode_t mode [`GPIID_PINS];

  // Sample history
  always_comb begin
    next_samp0 = pin_in; // R4
    next_samp1 = samp0;
  end

  // History starts at the idle level so release of reset is no edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      samp0 <= `GPIID_SAMP_RST;
      samp1 <= `GPIID_SAMP_RST;
    end else begin
      samp0 <= next_samp0;
      samp1 <= next_samp1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `GPIID_PINS; gi++) begin : g_pin
      // Mode decode from the four config bits
      always_comb begin
        unique case ({port_output_level[gi], port_direction[gi],
                      port_function_sel_high[gi], port_function_sel_low[gi]})
          4'b1010: mode[gi] = GPIID_MODE_DUAL; // R8
          4'b1111, 4'b0111: mode[gi] = GPIID_MODE_SINGLE; // R10
          4'b1011, 4'b0011: mode[gi] = GPIID_MODE_LEVEL;
          default: mode[gi] = GPIID_MODE_OTHER;
        endcase
      end

      // Request per pin
      always_comb begin
        unique case (mode[gi])
          GPIID_MODE_LEVEL:
            next_irq_req[gi] = (samp0[gi] == port_output_level[gi])
              && (samp1[gi] == port_output_level[gi]); // R3 R4 R5
          GPIID_MODE_DUAL:
            next_irq_req[gi] = samp0[gi] ^ samp1[gi]; // R7 R11
          GPIID_MODE_SINGLE:
            next_irq_req[gi] = port_output_level[gi] ? (samp0[gi] & ~samp1[gi])
              : (~samp0[gi] & samp1[gi]); // R9 R11
          GPIID_MODE_OTHER:
            next_irq_req[gi] = 1'b0;
        endcase
      end

      // Open-drain in interrupt modes: pin released, never driven high
      always_comb begin
        pin_out[gi] = 1'b0;
        pin_oe_n[gi] = 1'b1; // R2 R6
        if (mode[gi] == GPIID_MODE_OTHER) begin
          pin_out[gi] = port_output_level[gi];
          pin_oe_n[gi] = port_direction[gi];
        end
      end

      a_level_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_LEVEL) && $stable(mode[gi])
        && (samp0[gi] == port_output_level[gi]) && $stable(port_output_level[gi])
        && (samp1[gi] == port_output_level[gi]) |=> irq_req[gi]) // R4
        else $error("level request missing after two matching samples");

      a_level_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_LEVEL) && (samp0[gi] != port_output_level[gi])
        |=> !irq_req[gi]) // R5
        else $error("level request held after level changed");

      a_dual_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_DUAL) && (samp0[gi] != samp1[gi]) |=> irq_req[gi]) // R7
        else $error("dual edge missed");

      a_edge_once: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] != GPIID_MODE_LEVEL) && irq_req[gi] |=> !irq_req[gi]
        || $changed(samp1[gi]) || $changed(mode[gi])) // R11
        else $error("edge request longer than one cycle");

      a_single_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_SINGLE) && !port_output_level[gi]
        && samp0[gi] && !samp1[gi] |=> !irq_req[gi]) // R9
        else $error("rising edge accepted in falling mode");

      a_single_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_SINGLE) && !port_output_level[gi]
        && !samp0[gi] && samp1[gi] |=> irq_req[gi]) // R9
        else $error("falling edge missed");

      a_open_drain: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] != GPIID_MODE_OTHER) |-> pin_oe_n[gi] && !pin_out[gi]) // R2
        else $error("pin driven in interrupt mode");

      a_idle_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_OTHER) |=> !irq_req[gi] || $changed(mode[gi])) // R1
        else $error("request outside interrupt mode");

      // Pin at the selected level on two sampling edges, mode kept
      sequence s_pin_held;
        (mode[gi] == GPIID_MODE_LEVEL) && (pin_in[gi] == port_output_level[gi])
        ##1 (mode[gi] == GPIID_MODE_LEVEL) && (pin_in[gi] == port_output_level[gi])
        && $stable(port_output_level[gi])
        ##1 (mode[gi] == GPIID_MODE_LEVEL) && $stable(port_output_level[gi]);
      endsequence

      a_level_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_pin_held |=> irq_req[gi]) // R4
        else $error("level request late after pin held");

      a_level_short: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_LEVEL) && (samp1[gi] != port_output_level[gi])
        |=> !irq_req[gi]) // R4
        else $error("level request after a single sample");

      a_dual_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_DUAL) && (samp0[gi] == samp1[gi]) |=> !irq_req[gi]) // R7
        else $error("dual edge request without edge");

      a_single_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_SINGLE) && port_output_level[gi]
        && samp0[gi] && !samp1[gi] |=> irq_req[gi]) // R9
        else $error("rising edge missed");

      a_single_rsel: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_SINGLE) && port_output_level[gi]
        && !samp0[gi] && samp1[gi] |=> !irq_req[gi]) // R9
        else $error("falling edge accepted in rising mode");

      a_plain_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode[gi] == GPIID_MODE_OTHER) |-> (pin_out[gi] == port_output_level[gi])
        && (pin_oe_n[gi] == port_direction[gi])) // R2
        else $error("plain pin drive wrong");

      a_reset_clear: assert property (@(posedge core_clk)
        sys_rst |=> !irq_req[gi]) // R1
        else $error("request not cleared by reset");
    end
  endgenerate

  // Request registers, one per pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_irq_req; // R1 R6
    end
  end

endmodule : gpiid_detect

`default_nettype wire

// *** include/gpiid_cfg.svh ***
// Constants for the GPIO pin interrupt detector
// Assumes inclusion before the package and the design module
`ifndef GPIID_CFG_SVH
`define GPIID_CFG_SVH

`define GPIID_PINS 8
`define GPIID_CLK_HZ 50000000
`define GPIID_LEVEL_HOLD_CLKS 2
`define GPIID_RST_LEVEL 1'b0
`define GPIID_RST_DIR 1'b1
`define GPIID_RST_SEL_LOW 1'b0
`define GPIID_RST_SEL_HIGH 1'b0
// Released pins idle high, so the sample history starts high
`define GPIID_SAMP_RST 8'hff

`endif

// *** include/gpiid_pkg.sv ***
// Types for the GPIO pin interrupt detector
// Assumes gpiid_cfg.svh is on the include path
`include "gpiid_cfg.svh"
`default_nettype none

package gpiid_pkg;
  // Mode code decoded from {output level, direction, function high, function low}
  typedef enum logic [1:0] {
    GPIID_MODE_OTHER = 2'b00,
    GPIID_MODE_LEVEL = 2'b01,
    GPIID_MODE_DUAL = 2'b10,
    GPIID_MODE_SINGLE = 2'b11
  } gpiid_mode_t;
endpackage : gpiid_pkg

`default_nettype wire

// *** verification/gpiid_pin_dev.sv ***
// Model of the external devices and pull-ups on the port pins
// Assumes ext_low is changed just after a core_clk edge
`include "gpiid_cfg.svh"
`default_nettype none
module gpiid_pin_dev (
  input wire logic [`GPIID_PINS-1:0] ext_low,
  input wire logic [`GPIID_PINS-1:0] pin_out,
  input wire logic [`GPIID_PINS-1:0] pin_oe_n,
  output logic [`GPIID_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released line is pulled high unless the outside device pulls it low
  assign pin_in = (pin_oe_n | pin_out) & ~ext_low;
endmodule : gpiid_pin_dev
`default_nettype wire

// *** verification/gpiid_detect_tb.sv ***
// Testbench for the GPIO pin interrupt detector
// Assumes the package, design and pin device model are compiled first
`include "gpiid_cfg.svh"
`default_nettype none
module gpiid_detect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst;
  logic [`GPIID_PINS-1:0] ext_low, lvl, dir, sel_lo, sel_hi;
  logic [`GPIID_PINS-1:0] pin_in, pin_out, pin_oe_n, irq_req;
  int n_errors, n_tests;
  gpiid_detect gpiid_detect_i (.core_clk(core_clk), .sys_rst(sys_rst), .pin_in(pin_in),
    .port_output_level(lvl), .port_direction(dir), .port_function_sel_low(sel_lo),
    .port_function_sel_high(sel_hi), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq_req(irq_req));
  gpiid_pin_dev gpiid_pin_dev_i (.ext_low(ext_low), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task complete_run;
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task wait_irq(input logic [7:0] exp);
    int i;
    i = 0;
    while (irq_req !== exp && i < 8) begin
      step(1);
      i++;
    end
    check(irq_req, exp);
    if (irq_req !== exp) complete_run;
  endtask : wait_irq
  // Configuration bits written one per cycle in the documented order
  task cfg(input logic [7:0] l, input logic [7:0] h, input logic [7:0] s,
    input logic [7:0] d);
    lvl = l;
    step(1);
    sel_hi = h;
    step(1);
    sel_lo = s;
    step(1);
    dir = d;
    step(4);
  endtask : cfg
  initial begin
    sys_rst = 1'b1;
    ext_low = 8'h00;
    lvl = 8'h00;
    dir = 8'hff;
    sel_lo = 8'h00;
    sel_hi = 8'h00;
    n_errors = 0;
    n_tests = 0;
    step(5);
    sys_rst = 1'b0;
    ext_low = 8'h0f;
    step(3);
    check(irq_req, 8'h00);
    ext_low = 8'h00;
    cfg(8'hff, 8'hff, 8'h00, 8'h00);
    check(pin_oe_n, 8'hff);
    ext_low = 8'h0f;
    step(2);
    check(irq_req, 8'h0f);
    step(1);
    check(irq_req, 8'h00);
    ext_low = 8'h00;
    step(2);
    check(irq_req, 8'h0f);
    cfg(8'hff, 8'hff, 8'hff, 8'hff);
    lvl = 8'h33;
    step(3);
    ext_low = 8'hff;
    step(2);
    check(irq_req, 8'hcc);
    ext_low = 8'h00;
    step(2);
    check(irq_req, 8'h33);
    cfg(8'h0f, 8'hff, 8'hff, 8'h00);
    wait_irq(8'h0f);
    check(pin_oe_n, 8'hff);
    ext_low = 8'hf0;
    step(1);
    ext_low = 8'h00;
    repeat (4) begin
      step(1);
      check(irq_req, 8'h0f);
    end
    ext_low = 8'hf0;
    wait_irq(8'hff);
    step(6);
    check(irq_req, 8'hff);
    ext_low = 8'h00;
    wait_irq(8'h0f);
    sys_rst = 1'b1;
    lvl = 8'ha5;
    dir = 8'h00;
    sel_lo = 8'h00;
    sel_hi = 8'h00;
    step(2);
    sys_rst = 1'b0;
    step(1);
    check(irq_req, 8'h00);
    check(pin_out, 8'ha5);
    check(pin_oe_n, 8'h00);
    step(3);
    check(irq_req, 8'h00);
    complete_run;
  end
endmodule : gpiid_detect_tb
`default_nettype wire
